//--- verilog/dbgsc_defines.svh
// Constants for the debug request and scan strobe block.
// Assumes a 10 MHz clk_in and a TCK that is much slower.
// Contract
// RL1 - Internal request merges external request, control bit 1
// RL2 - Internal request is OR of both sources
// RL3 - External request reaches output without clock
// RL4 - Control bit applies on TCK fall in Run-Test/Idle
// RL5 - Provide scan cell multiplexer control output
// RL6 - Mux control changes in Update-IR, chain 3, drive instructions
// RL7 - Extest capture pulse in Capture-DR, chain 3
// RL8 - Internal extest capture output for tristate bus
// RL9 - Exported clock: main clock, or debug clock
// RL10 - External condition qualifies breakpoint matching
// RL11 - Level request enters debug after current instruction
// RL12 - Debug acknowledge high exactly in debug state
`ifndef DBGSC_DEFINES_SVH
`define DBGSC_DEFINES_SVH

`define DBGSC_CTRL_REQ_BIT 1
`define DBGSC_CTRL_WIDTH 4
`define DBGSC_SCAN_CHAIN_BS 4'h3
`define DBGSC_INSTR_EXTEST 4'h0
`define DBGSC_INSTR_INTEST 4'h1
`define DBGSC_INSTR_CLAMP 4'h2
`define DBGSC_INSTR_CLAMP_HIGH_IMPEDANCE_INSTR 4'h3
`define DBGSC_SYNC_STAGES 2
`define DBGSC_RST_MUX_CTRL 1'b0

`endif

//--- verilog/dbgsc_pkg.sv
// Types for the debug request and scan strobe block.
// Assumes the TAP state follows the standard 4-bit state coding.
package dbgsc_pkg;

  typedef enum logic [3:0] {
    DBGSC_EXIT2_DR = 4'h0,
    DBGSC_EXIT1_DR = 4'h1,
    DBGSC_SHIFT_DR = 4'h2,
    DBGSC_PAUSE_DR = 4'h3,
    DBGSC_SEL_IR = 4'h4,
    DBGSC_UPDATE_DR = 4'h5,
    DBGSC_CAPTURE_DR = 4'h6,
    DBGSC_SEL_DR = 4'h7,
    DBGSC_EXIT2_IR = 4'h8,
    DBGSC_EXIT1_IR = 4'h9,
    DBGSC_SHIFT_IR = 4'ha,
    DBGSC_PAUSE_IR = 4'hb,
    DBGSC_RUN_IDLE = 4'hc,
    DBGSC_UPDATE_IR = 4'hd,
    DBGSC_CAPTURE_IR = 4'he,
    DBGSC_RESET = 4'hf
  } dbgsc_tap_state_t;

  typedef logic [3:0] dbgsc_nibble_t;

endpackage

//--- verilog/dbgsc_tck_if.sv
// Synchronised TCK-side view shared by the sampler and the top.
// Assumes every member is on the clk_in domain.
`timescale 1ns/1ps
interface dbgsc_tck_if;
  import dbgsc_pkg::*;
  logic tck_rise;
  logic tck_fall;
  dbgsc_tap_state_t tap_state;
  dbgsc_nibble_t instr;
  dbgsc_nibble_t chain;
  logic ctrl_req;

  modport src (output tck_rise, tck_fall, tap_state, instr, chain, ctrl_req);
  modport snk (input tck_rise, tck_fall, tap_state, instr, chain, ctrl_req);
endinterface

//--- verilog/dbgsc_tck_sampler.sv
// Two-flop samplers for TCK and the TAP outputs, with TCK edge finding.
// Assumes TAP outputs change only away from TCK edges.
`timescale 1ns/1ps
`include "dbgsc_defines.svh"
module dbgsc_tck_sampler
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // TCK domain inputs
  input wire logic tck_in,
  input wire dbgsc_pkg::dbgsc_nibble_t tap_state_in,
  input wire dbgsc_pkg::dbgsc_nibble_t instr_in,
  input wire dbgsc_pkg::dbgsc_nibble_t chain_in,
  input wire logic [`DBGSC_CTRL_WIDTH-1:0] dbg_ctrl_in,
  // Synchronised view
  dbgsc_tck_if.src sync_if
);
  import dbgsc_pkg::*;

  localparam int W = 1 + 4 + 4 + 4 + 1;

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic tck_prev_r;
  logic [1:0] fill_r;
  wire [W-1:0] raw_in;
  wire tck_s;
  wire primed;

  assign raw_in = {tck_in, tap_state_in, instr_in, chain_in,
                   dbg_ctrl_in[`DBGSC_CTRL_REQ_BIT]};
  assign tck_s = sync_r[W-1];
  assign primed = (fill_r == 2'(`DBGSC_SYNC_STAGES + 1));

  ////////////////////////////////////////////////////////////////////////////
  // Two flop synchroniser
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      tck_prev_r <= 1'b0;
      fill_r <= 2'h0;
    end
    else
    begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      tck_prev_r <= tck_s;
      fill_r <= primed ? fill_r : fill_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and fields; edges wait for a full pipeline
  assign sync_if.tck_rise = primed & tck_s & ~tck_prev_r;
  assign sync_if.tck_fall = primed & ~tck_s & tck_prev_r;
  assign sync_if.tap_state = dbgsc_tap_state_t'(sync_r[12:9]);
  assign sync_if.instr = sync_r[8:5];
  assign sync_if.chain = sync_r[4:1];
  assign sync_if.ctrl_req = sync_r[0];
endmodule

//--- verilog/dbgsc_top.sv
// Debug request merge, scan strobes and exported clock.
// Assumes an outside TAP controller and core; clk_in samples TCK.
// Clock and request outputs are combinational; strobes come from flops.
`timescale 1ns/1ps
`include "dbgsc_defines.svh"
module dbgsc_top
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // TAP side
  input wire logic tck_in,
  input wire dbgsc_pkg::dbgsc_nibble_t tap_state_in,
  input wire dbgsc_pkg::dbgsc_nibble_t instr_in,
  input wire dbgsc_pkg::dbgsc_nibble_t chain_in,
  input wire logic [`DBGSC_CTRL_WIDTH-1:0] dbg_ctrl_in,
  // Debug request and core status
  input wire logic external_debug_request_in,
  input wire logic instr_done_in,
  input wire logic debug_exit_in,
  output logic internal_debug_request_out,
  output logic debug_state_ack_out,
  // Clocks
  input wire logic main_clock_in,
  input wire logic wait_stretch_n_in,
  input wire logic debug_clock_in,
  output logic exported_clock_out,
  // Breakpoint condition
  input wire logic external_condition_zero_in,
  output logic break_condition_out,
  // Scan strobes
  output logic scan_cell_mux_control_out,
  output logic extest_capture_pulse_chain_out,
  output logic extest_capture_internal_out
);
  import dbgsc_pkg::*;

  dbgsc_tck_if sync_if ();

  logic ctrl_req_r;
  logic ctrl_req_nxt;
  logic debug_state_r;
  logic debug_state_nxt;
  logic mux_ctrl_r;
  logic mux_ctrl_nxt;
  logic cap_chain_r;
  logic cap_chain_nxt;
  logic cap_int_r;
  logic cap_int_nxt;
  logic cond_meta_r;
  logic cond_r;

  wire chain_bs;
  wire drive_instr;
  wire in_capture_dr;
  wire is_extest;
  wire fall_idle;
  wire fall_update_ir;
  wire cap_start;
  wire cap_start_chain;
  wire req_any;
  wire mux_load;
  wire cap_stop;
  wire debug_enter;

  function automatic logic dbgsc_is_drive(input dbgsc_nibble_t ir);
    dbgsc_is_drive = (ir == `DBGSC_INSTR_INTEST) || (ir == `DBGSC_INSTR_EXTEST) ||
                     (ir == `DBGSC_INSTR_CLAMP) || (ir == `DBGSC_INSTR_CLAMP_HIGH_IMPEDANCE_INSTR);
  endfunction

  function automatic logic dbgsc_pulse_nxt(input logic start, input logic stop,
                                           input logic cur);
    dbgsc_pulse_nxt = start ? 1'b1 : (stop ? 1'b0 : cur);
  endfunction

  dbgsc_tck_sampler u_sampler
  (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .tck_in(tck_in),
    .tap_state_in(tap_state_in),
    .instr_in(instr_in),
    .chain_in(chain_in),
    .dbg_ctrl_in(dbg_ctrl_in),
    .sync_if(sync_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  assign chain_bs = (sync_if.chain == `DBGSC_SCAN_CHAIN_BS);
  assign drive_instr = dbgsc_is_drive(sync_if.instr);
  assign is_extest = (sync_if.instr == `DBGSC_INSTR_EXTEST);
  assign in_capture_dr = (sync_if.tap_state == DBGSC_CAPTURE_DR);
  assign fall_idle = sync_if.tck_fall && (sync_if.tap_state == DBGSC_RUN_IDLE);
  assign fall_update_ir = sync_if.tck_fall && (sync_if.tap_state == DBGSC_UPDATE_IR);
  assign cap_start = sync_if.tck_fall && in_capture_dr && is_extest;
  assign cap_start_chain = cap_start && chain_bs;

  ////////////////////////////////////////////////////////////////////////////
  // Debug request
  // Control bit only takes effect at a TCK fall in Run-Test/Idle
  assign ctrl_req_nxt = fall_idle ? sync_if.ctrl_req : ctrl_req_r; // see RL4
  // Pin path stays combinational so the request needs no clock
  assign req_any = external_debug_request_in | ctrl_req_r; // see RL1 see RL2 see RL3
  assign internal_debug_request_out = req_any; // see RL3

  // Enter after the current instruction, leave on core exit
  assign debug_enter = req_any && instr_done_in; // see RL11
  assign debug_state_nxt = debug_exit_in ? 1'b0 :
                           (debug_enter ? 1'b1 : debug_state_r); // see RL11
  assign debug_state_ack_out = debug_state_r; // see RL12

  ////////////////////////////////////////////////////////////////////////////
  // Exported clock
  assign exported_clock_out = debug_state_r ? debug_clock_in :
                              (main_clock_in & wait_stretch_n_in); // see RL9

  ////////////////////////////////////////////////////////////////////////////
  // Scan strobes
  // Mux control updates at Update-IR only with chain 3 selected
  assign mux_load = fall_update_ir && chain_bs; // see RL6
  assign mux_ctrl_nxt = mux_load ? drive_instr : mux_ctrl_r; // see RL5 see RL6
  // Pulse spans the TCK low phase: set on fall, cleared on rise
  assign cap_stop = sync_if.tck_rise;
  assign cap_chain_nxt = dbgsc_pulse_nxt(cap_start_chain, cap_stop, cap_chain_r); // see RL7
  assign cap_int_nxt = dbgsc_pulse_nxt(cap_start, cap_stop, cap_int_r); // see RL8
  assign scan_cell_mux_control_out = mux_ctrl_r; // see RL5
  assign extest_capture_pulse_chain_out = cap_chain_r; // see RL7
  assign extest_capture_internal_out = cap_int_r; // see RL8
  assign break_condition_out = cond_r; // see RL10

  ////////////////////////////////////////////////////////////////////////////
  // Control request latch
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_req_r <= 1'b0;
    end
    else
    begin
      ctrl_req_r <= ctrl_req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug state
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      debug_state_r <= 1'b0;
    end
    else
    begin
      debug_state_r <= debug_state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan cell mux control
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      mux_ctrl_r <= `DBGSC_RST_MUX_CTRL;
    end
    else
    begin
      mux_ctrl_r <= mux_ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chain capture pulse
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cap_chain_r <= 1'b0;
    end
    else
    begin
      cap_chain_r <= cap_chain_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal capture pulse
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cap_int_r <= 1'b0;
    end
    else
    begin
      cap_int_r <= cap_int_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition pin synchroniser, first stage
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cond_meta_r <= 1'b0;
    end
    else
    begin
      cond_meta_r <= external_condition_zero_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition pin synchroniser, second stage
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cond_r <= 1'b0;
    end
    else
    begin
      cond_r <= cond_meta_r;
    end
  end
endmodule

//--- dv/dbgsc_checker.sv
// Port assertions for the debug request and scan strobe block.
// Assumes one clk_in domain; bound to dbgsc_top by port name.
`timescale 1ns/1ps
module dbgsc_checker
(
  // Clock, reset and TAP view
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] tap_state_in,
  input wire logic [3:0] instr_in,
  input wire logic [3:0] chain_in,
  input wire logic [3:0] dbg_ctrl_in,
  // Request and debug state
  input wire logic external_debug_request_in,
  input wire logic debug_exit_in,
  input wire logic internal_debug_request_out,
  input wire logic debug_state_ack_out,
  // Strobes
  input wire logic scan_cell_mux_control_out,
  input wire logic extest_capture_pulse_chain_out,
  input wire logic extest_capture_internal_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  pin_req_a: assert property (
    external_debug_request_in |-> internal_debug_request_out) else $error("pin req");
  ctl_req_a: assert property (
    !external_debug_request_in && $rose(internal_debug_request_out)
    |-> dbg_ctrl_in[1] && tap_state_in == 4'hc) else $error("ctl req");
  ack_exit_a: assert property (
    debug_exit_in |=> !debug_state_ack_out) else $error("ack exit");
  ack_hold_a: assert property (
    debug_state_ack_out && !debug_exit_in |=> debug_state_ack_out) else $error("ack hold");
  mux_upd_a: assert property (
    $changed(scan_cell_mux_control_out) |-> tap_state_in == 4'hd && chain_in == 4'h3
    && scan_cell_mux_control_out == (instr_in <= 4'h3)) else $error("mux");
  cap_why_a: assert property (
    $rose(extest_capture_internal_out) |-> instr_in == 4'h0 && tap_state_in == 4'h6)
    else $error("cap cause");
  cap_chain_a: assert property (
    extest_capture_pulse_chain_out |-> extest_capture_internal_out && chain_in == 4'h3)
    else $error("cap chain");
  cap_wide_a: assert property (
    $rose(extest_capture_pulse_chain_out) |=> extest_capture_pulse_chain_out[*3])
    else $error("cap width");
endmodule
bind dbgsc_top dbgsc_checker chk_i (.*);

//--- dv/dbgsc_tap_model.sv
// Outside TAP controller and condition source.
// Assumes TCK stands high between frames.
`timescale 1ns/1ps
module dbgsc_tap_model
(
  // TAP side
  output logic tck_out,
  output logic [3:0] state_out,
  output logic [3:0] instr_out,
  output logic [3:0] chain_out,
  output logic [3:0] ctrl_out,
  output logic cond_out
);
  initial {tck_out, state_out, instr_out, chain_out, ctrl_out, cond_out} = 18'h3fe00;
  // One 1337 ns TCK frame, inputs steady around both edges
  task one_tck(input logic [3:0] st, ir, ch, ct);
    #37 {state_out, instr_out, chain_out, ctrl_out} = {st, ir, ch, ct};
    cond_out = ~cond_out;
    #400 tck_out = 1'h0;
    #400 tck_out = 1'h1;
    #500;
  endtask
endmodule

//--- dv/dbgsc_top_tb.sv
// Self-checking bench for the debug request and scan strobe block.
// Assumes the TAP model makes TCK; core status comes from here.
`timescale 1ns/1ps
module dbgsc_top_tb;
  import dbgsc_pkg::*;
  logic clk_in = 1'h0, sys_rst_in = 1'h1, tck_in, external_condition_zero_in;
  logic external_debug_request_in = 1'h0, instr_done_in = 1'h0, debug_exit_in = 1'h0;
  logic main_clock_in = 1'h0, wait_stretch_n_in = 1'h1, debug_clock_in = 1'h0;
  logic internal_debug_request_out, debug_state_ack_out, break_condition_out;
  logic scan_cell_mux_control_out, extest_capture_pulse_chain_out;
  logic extest_capture_internal_out, exported_clock_out;
  dbgsc_nibble_t tap_state_in, instr_in, chain_in, dbg_ctrl_in;
  logic [31:0] seed = 32'h55, r, rc;
  logic q[$];
  int num_errors = 0, samples_checked = 0, i;
  localparam logic [31:0] ir_tab = 32'h05342140, ch_tab = 32'h53353333;
  localparam logic [15:0] ct_tab = 16'h02d2;
  localparam logic [7:0] mx_tab = 8'h3d;
  dbgsc_tap_model tap (.tck_out(tck_in), .state_out(tap_state_in), .instr_out(instr_in),
    .chain_out(chain_in), .ctrl_out(dbg_ctrl_in), .cond_out(external_condition_zero_in));
  dbgsc_top dut (.*);
  initial forever #50 clk_in = ~clk_in;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always @(negedge clk_in)
  begin
    rc = xs();
    {main_clock_in, wait_stretch_n_in, debug_clock_in} <= rc[2:0];
  end
  task chk(input string nm, input logic e, g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Oldest capture note against each pulse seen
  always @(posedge extest_capture_internal_out)
  begin
    #1;
    if (q.size() == 0)
      chk("stray pulse", 1'h0, 1'h1);
    else
      chk("chain pulse", q.pop_front(), extest_capture_pulse_chain_out);
  end
  initial
  begin
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'h0;
    for (i = 0; i < 8; i++)
    begin
      @(negedge clk_in);
      r = xs();
      external_debug_request_in = r[0];
      #1 chk("pin request", r[0], internal_debug_request_out);
    end
    external_debug_request_in = 1'h0;
    $display("test pin request done");
    for (i = 0; i < 4; i++)
    begin
      tap.one_tck(i ? DBGSC_RUN_IDLE : DBGSC_SHIFT_DR, 4'hf, 4'h0, ct_tab[4*i+:4]);
      chk("ctrl request", i == 2, internal_debug_request_out);
    end
    $display("test ctrl request done");
    @(negedge clk_in);
    instr_done_in = 1'h1;
    @(negedge clk_in);
    chk("no entry", 1'h0, debug_state_ack_out);
    external_debug_request_in = 1'h1;
    @(negedge clk_in);
    {instr_done_in, external_debug_request_in} = 2'h0;
    #1 chk("entry", 1'h1, debug_state_ack_out);
    chk("debug clock", debug_clock_in, exported_clock_out);
    debug_exit_in = 1'h1;
    @(negedge clk_in);
    debug_exit_in = 1'h0;
    #1 chk("exit", 1'h0, debug_state_ack_out);
    chk("main clock", main_clock_in & wait_stretch_n_in, exported_clock_out);
    $display("test debug state done");
    for (i = 0; i < 8; i++)
    begin
      tap.one_tck(DBGSC_UPDATE_IR, ir_tab[4*i+:4], ch_tab[4*i+:4], 4'h0);
      chk("mux control", mx_tab[i], scan_cell_mux_control_out);
      chk("condition", external_condition_zero_in, break_condition_out);
    end
    $display("test mux control done");
    q.push_back(1'h1);
    q.push_back(1'h0);
    tap.one_tck(DBGSC_CAPTURE_DR, 4'h0, 4'h3, 4'h0);
    tap.one_tck(DBGSC_CAPTURE_DR, 4'h0, 4'h1, 4'h0);
    tap.one_tck(DBGSC_CAPTURE_DR, 4'h1, 4'h3, 4'h0);
    tap.one_tck(DBGSC_SHIFT_DR, 4'h0, 4'h3, 4'h0);
    chk("pulses seen", 1'h1, q.size() == 0);
    $display("test capture done");
    summarize();
  end
endmodule
